// [rtl/fca_top.sv]
/*
 * Flash configuration-space access block: the address and data register
 * pairs, the control register with read and write start, the access
 * sequencer and a classic Wishbone slave for software.
 * Assumes a single 100 MHz clock and a synchronous active-low reset.
 * The write path is a direct word write, with no write latches and no
 * unlock sequence in front of it.
 */
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module fca_top #(
   parameter int PROG_DEPTH = 256,
   // Arbitrary identification value, not a real part code
   parameter logic [13:0] DEVICE_ID = 14'h0123,
   parameter logic [13:0] CONFIG_1 = 14'h3fff,
   parameter logic [13:0] CONFIG_2 = 14'h3fff
) (
   // Clock and reset
   input wire logic I_CLOCK,
   input wire logic I_RESET_N,
   // Wishbone slave
   input wire fca_pkg::fca_wb_req_s I_WB_REQ,
   output logic O_WB_ACK,
   output logic [31:0] O_WB_DAT,
   // Core pipeline
   output logic O_INSN_SQUASH,
   output logic O_BUSY
);
   import fca_pkg::*;

   // ****************************************************************
   // Elaboration check
   // ****************************************************************
   // The address pair reaches 32768 words; a deeper store is never used
   if (PROG_DEPTH < 2 || PROG_DEPTH > (1 << ADDR_W)) begin
      $error("fca_top: PROG_DEPTH must lie between 2 and 32768");
   end

   // ****************************************************************
   // Registers and nets
   // ****************************************************************
   logic [7:0] data_low;
   logic [7:0] data_high;
   logic [7:0] addr_low;
   logic [7:0] addr_high;
   logic read_start;
   logic write_start;
   logic write_error;
   logic cfg_select;
   fca_state_e state;
   fca_state_e next_state;
   logic [ADDR_W-1:0] word_addr;
   logic [WORD_W-1:0] word_wdata;
   logic [WORD_W-1:0] prog_rdata;
   logic [WORD_W-1:0] cfg_rdata;
   logic cfg_mapped;
   logic cfg_writable;
   logic [WORD_W-1:0] fetched;
   logic do_write;
   logic write_ok;
   logic bus_req;
   logic bus_wr;
   logic load_word;
   logic wr_data_low;
   logic wr_data_high;
   logic wr_addr_low;
   logic wr_addr_high;
   logic wr_control;

   // ****************************************************************
   // Word address and data assembly
   // ****************************************************************
   // 15-bit address from the pair, 14-bit word from the pair
   assign word_addr = {addr_high[6:0], addr_low};
   assign word_wdata = {data_high[5:0], data_low};

   // Select chooses the source of the fetched word;
   // an unlisted configuration offset loads zeros
   always_comb begin
      fetched = prog_rdata;
      if (cfg_select) begin
         fetched = cfg_mapped ? cfg_rdata : '0;
      end
   end

   // Write allowed into program memory or writable config words;
   // a rejected write leaves the word alone and raises the error flag
   assign write_ok = !cfg_select || cfg_writable;
   assign do_write = (state == ST_WRITE) && write_ok;
   assign load_word = (state == ST_SQUASH);

   // ****************************************************************
   // Storage
   // ****************************************************************
   // Program memory; the word address aliases modulo its depth
   fca_prog_mem #(
      .DEPTH(PROG_DEPTH)
   ) u_prog_mem (
      .i_clock(I_CLOCK),
      .i_addr(word_addr),
      .i_write(do_write && !cfg_select),
      .i_wdata(word_wdata),
      .o_rdata(prog_rdata)
   );

   // Configuration region; user IDs are blank after reset
   fca_cfg_space #(
      .DEVICE_ID(DEVICE_ID),
      .CONFIG_1(CONFIG_1),
      .CONFIG_2(CONFIG_2)
   ) u_cfg_space (
      .i_clock(I_CLOCK),
      .i_reset_n(I_RESET_N),
      .i_addr(word_addr),
      .i_write(do_write && cfg_select),
      .i_wdata(word_wdata),
      .o_rdata(cfg_rdata),
      .o_mapped(cfg_mapped),
      .o_writable(cfg_writable)
   );

   // ****************************************************************
   // Wishbone slave
   // ****************************************************************
   // A request is taken only while ack is low
   assign bus_req = I_WB_REQ.cyc && I_WB_REQ.stb && !O_WB_ACK;
   assign bus_wr = bus_req && I_WB_REQ.we && I_WB_REQ.sel[0];

   // Register write strobes, one per offset; a write with sel[0] low
   // is answered but changes nothing
   assign wr_data_low = bus_wr && (I_WB_REQ.adr == OFS_DATA_LOW);
   assign wr_data_high = bus_wr && (I_WB_REQ.adr == OFS_DATA_HIGH);
   assign wr_addr_low = bus_wr && (I_WB_REQ.adr == OFS_ADDR_LOW);
   assign wr_addr_high = bus_wr && (I_WB_REQ.adr == OFS_ADDR_HIGH);
   assign wr_control = bus_wr && (I_WB_REQ.adr == OFS_CONTROL);

   // Acknowledge one cycle after the request, drop the cycle after;
   // masking the request with ack keeps a held strobe from being
   // taken twice
   always_ff @(posedge I_CLOCK) begin
      if (!I_RESET_N) begin
         O_WB_ACK <= 1'b0;
      end else begin
         O_WB_ACK <= bus_req;
      end
   end

   // Registered read data; unmapped offsets read zero
   // The unused data and address bits are forced here, not stored
   always_ff @(posedge I_CLOCK) begin
      if (!I_RESET_N) begin
         O_WB_DAT <= '0;
      end else if (bus_req && !I_WB_REQ.we) begin
         unique case (I_WB_REQ.adr)
            OFS_DATA_LOW: O_WB_DAT <= {24'h000000, data_low};
            OFS_DATA_HIGH: begin
               O_WB_DAT <= {24'h000000, data_high & DATA_HIGH_MASK};
            end
            OFS_ADDR_LOW: O_WB_DAT <= {24'h000000, addr_low};
            OFS_ADDR_HIGH: begin
               O_WB_DAT <= {24'h000000, addr_high | ADDR_HIGH_FILL};
            end
            OFS_CONTROL: begin
               O_WB_DAT <= {24'h000000, 1'b1, cfg_select, 3'h0,
                            write_error, write_start, read_start};
            end
            default: O_WB_DAT <= '0;
         endcase
      end
   end

   // ****************************************************************
   // Address register pair
   // ****************************************************************
   // Cleared by every reset; writes never reach the unused top bit
   always_ff @(posedge I_CLOCK) begin
      if (!I_RESET_N) begin
         addr_low <= ADDR_RESET;
         addr_high <= ADDR_RESET;
      end else begin
         if (wr_addr_low) begin
            addr_low <= I_WB_REQ.dat[7:0];
         end
         if (wr_addr_high) begin
            addr_high <= I_WB_REQ.dat[7:0] & ADDR_HIGH_MASK;
         end
      end
   end

   // ****************************************************************
   // Data register pair
   // ****************************************************************
   // No reset: contents survive resets; the fetched word wins over a
   // bus write in the load cycle
   // Until the first load or write the pair holds no defined value
   always_ff @(posedge I_CLOCK) begin
      if (load_word) begin
         data_low <= fetched[7:0];
         data_high <= {2'b00, fetched[13:8]};
      end else begin
         if (wr_data_low) begin
            data_low <= I_WB_REQ.dat[7:0];
         end
         if (wr_data_high) begin
            data_high <= I_WB_REQ.dat[7:0] & DATA_HIGH_MASK;
         end
      end
   end

   // ****************************************************************
   // Control register
   // ****************************************************************
   // Select bit is plain read/write
   always_ff @(posedge I_CLOCK) begin
      if (!I_RESET_N) begin
         cfg_select <= 1'b0;
      end else if (wr_control) begin
         cfg_select <= I_WB_REQ.dat[CTL_CFG_SELECT];
      end
   end

   // Read start: software may only set it, the word load clears it
   always_ff @(posedge I_CLOCK) begin
      if (!I_RESET_N) begin
         read_start <= 1'b0;
      end else if (load_word) begin
         read_start <= 1'b0;
      end else if (wr_control && I_WB_REQ.dat[CTL_READ_START]) begin
         read_start <= 1'b1;
      end
   end

   // Write start: software may only set it, the write slot clears it
   always_ff @(posedge I_CLOCK) begin
      if (!I_RESET_N) begin
         write_start <= 1'b0;
      end else if (state == ST_WRITE) begin
         write_start <= 1'b0;
      end else if (wr_control && I_WB_REQ.dat[CTL_WRITE_START]) begin
         write_start <= 1'b1;
      end
   end

   // Write error: set on a rejected write, cleared by writing zero;
   // the hardware set wins over a clear in the same cycle
   always_ff @(posedge I_CLOCK) begin
      if (!I_RESET_N) begin
         write_error <= 1'b0;
      end else if (state == ST_WRITE && !write_ok) begin
         write_error <= 1'b1;
      end else if (wr_control && !I_WB_REQ.dat[CTL_WRITE_ERROR]) begin
         write_error <= 1'b0;
      end
   end

   // ****************************************************************
   // Access sequencer
   // ****************************************************************
   // Read: one cycle for the instruction that runs, one for the one
   // that is ignored, the word loads at the end of the second
   // Read start wins when both start bits are set
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (read_start) begin
               next_state = ST_EXEC;
            end else if (write_start) begin
               next_state = ST_WRITE;
            end
         end
         ST_EXEC: next_state = ST_SQUASH;
         ST_SQUASH: next_state = ST_IDLE;
         ST_WRITE: next_state = ST_IDLE;
      endcase
   end

   // Sequencer state register
   always_ff @(posedge I_CLOCK) begin
      if (!I_RESET_N) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Squash marks the ignored instruction slot, one cycle per read
   always_ff @(posedge I_CLOCK) begin
      if (!I_RESET_N) begin
         O_INSN_SQUASH <= 1'b0;
      end else begin
         O_INSN_SQUASH <= (next_state == ST_SQUASH);
      end
   end

   // Busy covers every sequencer slot, read or write
   always_ff @(posedge I_CLOCK) begin
      if (!I_RESET_N) begin
         O_BUSY <= 1'b0;
      end else begin
         O_BUSY <= (next_state != ST_IDLE);
      end
   end

endmodule : fca_top

// [rtl/fca_pkg.sv]
/*
 * Package for the flash configuration-space access block: register offsets,
 * field positions, reset values, configuration-region layout, the bus
 * request carrier and the sequencer state type.
 * Assumes a classic Wishbone slave with 32-bit data and byte addresses.
 */
package fca_pkg;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] OFS_DATA_LOW = 8'h00;
   localparam logic [7:0] OFS_DATA_HIGH = 8'h04;
   localparam logic [7:0] OFS_ADDR_LOW = 8'h08;
   localparam logic [7:0] OFS_ADDR_HIGH = 8'h0c;
   localparam logic [7:0] OFS_CONTROL = 8'h10;

   // ****************************************************************
   // Field positions and widths
   // ****************************************************************
   localparam int WORD_W = 14;
   localparam int ADDR_W = 15;
   localparam int CTL_READ_START = 0;
   localparam int CTL_WRITE_START = 1;
   localparam int CTL_WRITE_ERROR = 2;
   localparam int CTL_CFG_SELECT = 6;
   localparam int CTL_UNUSED_ONE = 7;
   localparam logic [7:0] DATA_HIGH_MASK = 8'h3f;
   localparam logic [7:0] ADDR_HIGH_MASK = 8'h7f;
   localparam logic [7:0] ADDR_HIGH_FILL = 8'h80;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0] ADDR_RESET = 8'h00;
   localparam logic [13:0] BLANK_WORD = 14'h3fff;

   // ****************************************************************
   // Configuration region layout (word offsets within the region)
   // ****************************************************************
   localparam logic [14:0] CFG_USER_ID_FIRST = 15'h0000;
   localparam logic [14:0] CFG_USER_ID_LAST = 15'h0003;
   localparam logic [14:0] CFG_DEVICE_ID = 15'h0006;
   localparam logic [14:0] CFG_WORD_1 = 15'h0007;
   localparam logic [14:0] CFG_WORD_2 = 15'h0008;
   localparam int USER_ID_COUNT = 4;

   // ****************************************************************
   // Sequencer timing: cycles from read start to data load
   // ****************************************************************
   localparam int READ_CYCLES = 2;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } fca_wb_req_s;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC,
      ST_SQUASH,
      ST_WRITE
   } fca_state_e;

endpackage : fca_pkg

// [rtl/fca_prog_mem.sv]
/*
 * Program memory model held in flip-flops, one word per index.
 * Assumes the word address is wider than the index; upper bits alias.
 */
`timescale 1ns/1ps
module fca_prog_mem #(
   parameter int DEPTH = 256
) (
   // Clock
   input wire logic i_clock,
   // Access
   input wire logic [fca_pkg::ADDR_W-1:0] i_addr,
   input wire logic i_write,
   input wire logic [fca_pkg::WORD_W-1:0] i_wdata,
   output logic [fca_pkg::WORD_W-1:0] o_rdata
);
   import fca_pkg::*;

   localparam int IDX_W = $clog2(DEPTH);

   // ****************************************************************
   // Elaboration check
   // ****************************************************************
   if (DEPTH < 2 || DEPTH > (1 << ADDR_W) || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("fca_prog_mem: DEPTH must be a power of two up to 32768");
   end

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [WORD_W-1:0] mem [DEPTH];
   logic [IDX_W-1:0] idx;

   assign idx = i_addr[IDX_W-1:0];

   // Word write
   always_ff @(posedge i_clock) begin
      if (i_write) begin
         mem[idx] <= i_wdata;
      end
   end

   // Word read
   assign o_rdata = mem[idx];

endmodule : fca_prog_mem

// [rtl/fca_cfg_space.sv]
/*
 * Configuration region: four user ID words, the identification word and
 * two configuration words. Decodes which offsets exist and which accept
 * writes. Assumes offsets relative to the region start.
 */
`timescale 1ns/1ps
module fca_cfg_space #(
   // Arbitrary identification value, not a real part code
   parameter logic [13:0] DEVICE_ID = 14'h0123,
   parameter logic [13:0] CONFIG_1 = 14'h3fff,
   parameter logic [13:0] CONFIG_2 = 14'h3fff
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_reset_n,
   // Access
   input wire logic [fca_pkg::ADDR_W-1:0] i_addr,
   input wire logic i_write,
   input wire logic [fca_pkg::WORD_W-1:0] i_wdata,
   output logic [fca_pkg::WORD_W-1:0] o_rdata,
   output logic o_mapped,
   output logic o_writable
);
   import fca_pkg::*;

   logic [WORD_W-1:0] user_id [USER_ID_COUNT];
   logic is_user;

   // ****************************************************************
   // Decode
   // ****************************************************************
   assign is_user = (i_addr >= CFG_USER_ID_FIRST) &&
                    (i_addr <= CFG_USER_ID_LAST);
   assign o_writable = is_user;

   // User ID words, blank after reset
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         for (int i = 0; i < USER_ID_COUNT; i++) begin
            user_id[i] <= BLANK_WORD;
         end
      end else if (i_write && is_user) begin
         user_id[i_addr[1:0]] <= i_wdata;
      end
   end

   // Read mux; unlisted offsets read as zero
   always_comb begin
      o_rdata = '0;
      o_mapped = 1'b1;
      if (is_user) begin
         o_rdata = user_id[i_addr[1:0]];
      end else if (i_addr == CFG_DEVICE_ID) begin
         o_rdata = DEVICE_ID;
      end else if (i_addr == CFG_WORD_1) begin
         o_rdata = CONFIG_1;
      end else if (i_addr == CFG_WORD_2) begin
         o_rdata = CONFIG_2;
      end else begin
         o_mapped = 1'b0;
      end
   end

endmodule : fca_cfg_space

// [tb/fca_top_assertions.sv]
/*
 * Checker for the flash configuration-space access block.
 * Assumes it sees only the ports of fca_top; bound at the foot.
 */
`timescale 1ns/1ps
module fca_top_assertions (
   // Clock and reset
   input wire logic I_CLOCK,
   input wire logic I_RESET_N,
   // Bus and pipeline signals
   input wire fca_pkg::fca_wb_req_s I_WB_REQ,
   input wire logic O_WB_ACK,
   input wire logic [31:0] O_WB_DAT,
   input wire logic O_INSN_SQUASH,
   input wire logic O_BUSY
);
   import fca_pkg::*;
   logic taken;
   logic rd_take;
   logic rs_take;

   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (!I_RESET_N);

   // ****************************************************************
   // Request decode
   // ****************************************************************
   // Accepted request, accepted read, and an idle read start
   assign taken = I_WB_REQ.cyc && I_WB_REQ.stb && !O_WB_ACK;
   assign rd_take = taken && !I_WB_REQ.we;
   assign rs_take = taken && I_WB_REQ.we && I_WB_REQ.sel[0]
      && I_WB_REQ.adr == OFS_CONTROL
      && I_WB_REQ.dat[CTL_READ_START] && !O_BUSY;

   // ****************************************************************
   // Properties
   // ****************************************************************
   property p_ack_resp;
      taken |=> O_WB_ACK;
   endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("no ack");

   property p_ack_once;
      O_WB_ACK |=> !O_WB_ACK;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack held");

   property p_dat_upper;
      O_WB_ACK |-> O_WB_DAT[31:8] == 24'h0;
   endproperty
   a_dat_upper: assert property (p_dat_upper) else $error("upper data");

   property p_addr_fill;
      rd_take && I_WB_REQ.adr == OFS_ADDR_HIGH |=> O_WB_DAT[7];
   endproperty
   a_addr_fill: assert property (p_addr_fill)
      else $error("address high bit 7 not one");

   property p_data_top;
      rd_take && I_WB_REQ.adr == OFS_DATA_HIGH |=> O_WB_DAT[7:6] == 2'h0;
   endproperty
   a_data_top: assert property (p_data_top)
      else $error("data high bits 7:6 not zero");

   property p_busy_start;
      rs_take |-> ##2 O_BUSY;
   endproperty
   a_busy_start: assert property (p_busy_start)
      else $error("read did not start");

   property p_squash;
      rs_take |-> ##3 O_INSN_SQUASH;
   endproperty
   a_squash: assert property (p_squash)
      else $error("squash late or missing");

   property p_squash_end;
      O_INSN_SQUASH |-> O_BUSY ##1 (!O_BUSY && !O_INSN_SQUASH);
   endproperty
   a_squash_end: assert property (p_squash_end)
      else $error("read did not finish after squash");

   // Main scenarios reached
   c_cfg_read: cover property (rs_take && I_WB_REQ.dat[CTL_CFG_SELECT]);
   c_squash: cover property (O_INSN_SQUASH);
   c_write: cover property (taken && I_WB_REQ.we
      && I_WB_REQ.adr == OFS_CONTROL && I_WB_REQ.dat[CTL_WRITE_START]);
endmodule : fca_top_assertions

bind fca_top fca_top_assertions fca_top_assertions_inst (
   .I_CLOCK(I_CLOCK),
   .I_RESET_N(I_RESET_N),
   .I_WB_REQ(I_WB_REQ),
   .O_WB_ACK(O_WB_ACK),
   .O_WB_DAT(O_WB_DAT),
   .O_INSN_SQUASH(O_INSN_SQUASH),
   .O_BUSY(O_BUSY)
);

// [tb/fca_top_tb.sv]
/*
 * Self-checking bench for the flash configuration-space access block.
 * Assumes the Wishbone map and sequencer timing of fca_pkg.
 */
`timescale 1ns/1ps
module fca_top_tb;
   import fca_pkg::*;
   localparam logic [13:0] DEV_ID = 14'h0a5c; // Arbitrary value
   localparam logic [13:0] CW1 = 14'h1357;
   localparam logic [13:0] CW2 = 14'h2468;
   logic [14:0] ro_adr [3] = '{15'h0006, 15'h0007, 15'h0008};
   logic [13:0] ro_val [3] = '{DEV_ID, CW1, CW2};
   logic [14:0] un_adr [3] = '{15'h0004, 15'h0005, 15'h0009};
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   fca_wb_req_s req = '0;
   logic ack;
   logic busy;
   logic squash;
   logic [31:0] dat;
   int fails = 0;
   int checked = 0;
   int nsq = 0;
   int nrd = 0;

   fca_top #(.PROG_DEPTH(256), .DEVICE_ID(DEV_ID), .CONFIG_1(CW1),
      .CONFIG_2(CW2)) fca_top_inst (
      .I_CLOCK(clock),
      .I_RESET_N(reset_n),
      .I_WB_REQ(req),
      .O_WB_ACK(ack),
      .O_WB_DAT(dat),
      .O_INSN_SQUASH(squash),
      .O_BUSY(busy)
   );

   // 100 MHz clock
   always #5 clock = ~clock;

   // Count squash pulses
   always @(posedge clock) begin
      if (squash === 1'b1) nsq++;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic conclude();
      if (fails == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      checked++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask : chk

   // One classic cycle: request held until ack is sampled high at a
   // rising edge; read data taken and request released at that edge
   task automatic bus(input logic we, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q);
      int n;
      @(posedge clock);
      req <= '{1'b1, 1'b1, we, a, 4'h1, {24'h0, d}};
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) begin
         fails++;
         conclude();
      end
      q = dat[7:0];
      req <= '0;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input string nm, input logic [7:0] a,
      input logic [7:0] e);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(nm, {8'h00, e}, {8'h00, q});
   endtask : rd

   // High byte cleared for region offsets
   task automatic set_addr(input logic [14:0] a);
      wr(OFS_ADDR_LOW, a[7:0]);
      wr(OFS_ADDR_HIGH, {1'b0, a[14:8]});
   endtask : set_addr

   // Top bits written as ones, they must be dropped
   task automatic put(input logic [13:0] w);
      wr(OFS_DATA_LOW, w[7:0]);
      wr(OFS_DATA_HIGH, {2'b11, w[13:8]});
   endtask : put

   task automatic word(input string nm, input logic [13:0] e);
      logic [7:0] l;
      logic [7:0] h;
      bus(1'b0, OFS_DATA_LOW, 8'h00, l);
      bus(1'b0, OFS_DATA_HIGH, 8'h00, h);
      chk(nm, {2'b00, e}, {h, l});
   endtask : word

   // Start a sequence, see it go busy, then wait for it to finish
   task automatic go(input logic [7:0] ctl);
      int n;
      wr(OFS_CONTROL, ctl);
      if (ctl[0]) nrd++;
      @(posedge clock);
      chk("busy", 16'h0001, {15'h0000, busy});
      n = 0;
      while (busy !== 1'b0 && n < 20) begin
         @(posedge clock);
         n++;
      end
      if (n >= 20) begin
         fails++;
         conclude();
      end
   endtask : go

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      rd("addr low reset", OFS_ADDR_LOW, 8'h00);
      rd("addr high reset", OFS_ADDR_HIGH, 8'h80);
      wr(OFS_ADDR_HIGH, 8'hff);
      rd("addr high", OFS_ADDR_HIGH, 8'hff);
      wr(OFS_ADDR_LOW, 8'ha5);
      rd("addr low", OFS_ADDR_LOW, 8'ha5);
      put(14'h2a5a);
      rd("data high", OFS_DATA_HIGH, 8'h2a);
      rd("data low", OFS_DATA_LOW, 8'h5a);
      // Program memory write, then read back and compare
      set_addr(15'h0123);
      go(8'h02);
      put(14'h0000);
      go(8'h01);
      word("prog word", 14'h2a5a);
      rd("control idle", OFS_CONTROL, 8'h80);
      // User IDs: reset value, then write and read back
      set_addr(15'h0000);
      go(8'h41);
      word("user id blank", 14'h3fff);
      set_addr(15'h0002);
      put(14'h1234);
      go(8'h42);
      put(14'h0000);
      go(8'h41);
      word("user id", 14'h1234);
      rd("control cfg", OFS_CONTROL, 8'hc0);
      // Read-only words refuse writes
      foreach (ro_adr[i]) begin
         set_addr(ro_adr[i]);
         put(14'h0000);
         go(8'h42);
         rd("write error", OFS_CONTROL, 8'hc4);
         go(8'h41);
         word("read only word", ro_val[i]);
      end
      // Unlisted offsets read zero
      foreach (un_adr[i]) begin
         set_addr(un_adr[i]);
         put(14'h3fff);
         go(8'h41);
         word("unlisted", 14'h0000);
      end
      chk("squash count", 16'(nrd), 16'(nsq));
      // Reset mid-run keeps the data pair
      put(14'h0777);
      set_addr(15'h0155);
      @(posedge clock);
      reset_n <= 1'b0;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      rd("addr low after reset", OFS_ADDR_LOW, 8'h00);
      rd("addr high after reset", OFS_ADDR_HIGH, 8'h80);
      word("data kept", 14'h0777);
      conclude();
   end
endmodule : fca_top_tb
